// ### charger_pkg.sv
// shared constants and types for the charger command register bank
package charger_pkg;
    // command bytes
    localparam logic [7:0] CMD_OPTION = 8'h12;
    localparam logic [7:0] CMD_CHG_CUR = 8'h14;
    localparam logic [7:0] CMD_CHG_VOLT = 8'h15;
    localparam logic [7:0] CMD_IN_CUR = 8'h3F;
    localparam logic [7:0] CMD_MAKER_ID = 8'hFE;
    localparam logic [7:0] CMD_PART_ID = 8'hFF;
    // 7-bit slave address, address byte 0x12 with the direction bit low
    localparam logic [6:0] SLAVE_ADDR7 = 7'h09;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_TX_BIT = 4'h7;
    // values after reset
    localparam logic [15:0] OPTION_RST = 16'hF902;
    localparam logic [15:0] CHG_CUR_RST = 16'h0000;
    localparam logic [15:0] CHG_VOLT_RST = 16'h0000;
    localparam logic [15:0] IN_CUR_RST = 16'h1000;
    // implemented setting bits: 7, 11 and 6 bits wide
    localparam logic [15:0] CHG_CUR_MASK = 16'h1FC0;
    localparam logic [15:0] CHG_VOLT_MASK = 16'h7FF0;
    localparam logic [15:0] IN_CUR_MASK = 16'h1F80;
    // read-only option bits: adapter present, boost indication
    localparam logic [15:0] OPTION_RO_MASK = 16'h0014;
    // identification words, values arbitrary
    localparam logic [15:0] MAKER_ID_VAL = 16'h5A3C;
    localparam logic [15:0] PART_ID_VAL = 16'h00A7;
    // option field positions
    localparam int OPT_DEGLITCH_BIT = 15;
    localparam int OPT_WDOG_HI = 14;
    localparam int OPT_WDOG_LO = 13;
    localparam int OPT_DEPL_HI = 12;
    localparam int OPT_DEPL_LO = 11;
    localparam int OPT_FREQ_DIR_BIT = 10;
    localparam int OPT_FREQ_EN_BIT = 9;
    localparam int OPT_HS_SHORT_BIT = 8;
    localparam int OPT_LEARN_BIT = 6;
    localparam int OPT_ADAPTER_BIT = 4;
    localparam int OPT_BOOST_IND_BIT = 2;
    // watchdog codes
    localparam logic [1:0] WDOG_OFF = 2'h0;
    localparam logic [1:0] WDOG_175 = 2'h3;
    // depletion threshold codes
    localparam logic [1:0] DEPL_5919 = 2'h0;
    localparam logic [1:0] DEPL_6265 = 2'h2;
    localparam logic [1:0] DEPL_7097 = 2'h3;
    // timing
    localparam longint CLK_HZ = 64'd10000000;
    localparam longint WDOG_SHORT_S = 64'd44;
    localparam longint WDOG_LONG_S = 64'd175;
    localparam longint DEGLITCH_SHORT_MS = 64'd150;
    localparam longint DEGLITCH_LONG_MS = 64'd1300;
    localparam int TMR_W = 32;
    localparam logic [31:0] WDOG_SHORT_CYC = 32'(WDOG_SHORT_S * CLK_HZ);
    localparam logic [31:0] WDOG_LONG_CYC = 32'(WDOG_LONG_S * CLK_HZ);
    localparam logic [31:0] DEGLITCH_SHORT_CYC = 32'(DEGLITCH_SHORT_MS * CLK_HZ / 64'd1000);
    localparam logic [31:0] DEGLITCH_LONG_CYC = 32'(DEGLITCH_LONG_MS * CLK_HZ / 64'd1000);
    // serial slave states, gray in listed order and along the write path
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_ACK = 4'h3,
        ST_CMD = 4'h2,
        ST_CMD_ACK = 4'h6,
        ST_WDATA = 4'h7,
        ST_WDATA_ACK = 4'h5,
        ST_RDATA = 4'h4,
        ST_RDATA_ACK = 4'hC
    } smb_state_e;
endpackage

// ### line_edge.sv
// registered copy of a bus line with rise and fall pulses
`timescale 1ns/1ps
module line_edge #(
    parameter logic IDLE_LVL = 1'b1
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic raw,
    output logic level,
    output logic rise,
    output logic fall
);
    logic level_ff;
    logic prev_ff;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            level_ff <= IDLE_LVL;
            prev_ff <= IDLE_LVL;
        end else begin
            level_ff <= raw;
            prev_ff <= level_ff;
        end
    end

    assign level = level_ff;
    assign rise = level_ff & ~prev_ff;
    assign fall = ~level_ff & prev_ff;
endmodule

// ### interval_timer.sv
// up-counter that flags when a run of limit cycles has elapsed
`timescale 1ns/1ps
module interval_timer #(
    parameter int W = 32
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic restart,
    input wire logic run,
    input wire logic [W-1:0] limit,
    output logic expired
);
    logic [W-1:0] count_ff;
    logic expired_ff;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            count_ff <= '0;
        end else if (restart) begin
            count_ff <= '0;
        end else if (run && !expired_ff) begin
            count_ff <= count_ff + W'(1);
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            expired_ff <= 1'b0;
        end else if (restart) begin
            expired_ff <= 1'b0;
        end else if (run && (count_ff >= limit - W'(1))) begin
            expired_ff <= 1'b1;
        end
    end

    assign expired = expired_ff;
endmodule

// ### charger_command_register_bank.sv
// command register bank of the charge controller behind its serial slave port
// What this block does
// - six commands, reached only by read-word or write-word on the command byte
// - command FE reads a fixed maker code; writes do nothing
// - command FF reads a fixed part code; read-only
// - option register at 12 is read/write, resets to F902
// - charge current at 14 is read/write, 7 setting bits, resets to 0000
// - charge voltage at 15 is read/write, 11 setting bits, resets to zero
// - input current at 3F is read/write, 6 setting bits, resets to 1000
// - first adapter insertion after reset always uses the 150 ms deglitch
// - option bit 15 picks 150 ms or 1.3 s once the adapter switch opened
// - serial writes accepted only above lockout and detect above 0.6 V
// - option bits 14:13 pick watchdog off, 44 s or 175 s
// - enabled watchdog with no setting write in time suspends charging
// - a charge voltage or current write resumes a suspended charge
// - during boost an enabled watchdog always uses 175 s
// - learn cycle depleted: battery switch off, adapter switch on
// - boost stops when the battery falls below the depletion level
// - option bits 12:11 pick the depletion threshold fraction
// - zero charge voltage setting disables the depletion comparison
// - option bit 10 picks frequency shift down or up by 18 percent
// - option bit 9 enables the frequency shift
// - option bit 8 enables the high side short comparator at 750 mV
// - answers only as slave at address byte 12, never drives transfers
`timescale 1ns/1ps
module charger_command_register_bank import charger_pkg::*; #(
    parameter logic [31:0] WDOG_SHORT_CYC_P = WDOG_SHORT_CYC,
    parameter logic [31:0] WDOG_LONG_CYC_P = WDOG_LONG_CYC,
    parameter logic [31:0] DEGLITCH_SHORT_CYC_P = DEGLITCH_SHORT_CYC,
    parameter logic [31:0] DEGLITCH_LONG_CYC_P = DEGLITCH_LONG_CYC
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic vcc_above_undervoltage_lockout,
    input wire logic detect_above_enable_level,
    input wire logic adapter_detect_input,
    input wire logic bat_below_depletion,
    input wire logic boost_active,
    output logic adapter_present_indication,
    output logic adapter_switch,
    output logic battery_switch,
    output logic charge_suspended,
    output logic boost_stop,
    output logic depletion_cmp_en,
    output logic [1:0] depletion_threshold_sel,
    output logic freq_adjust_up,
    output logic freq_adjust_en,
    output logic high_side_short_threshold,
    output logic [15:0] option_value,
    output logic [15:0] charge_current_value,
    output logic [15:0] charge_voltage_value,
    output logic [15:0] input_current_value
);
    logic scl_lvl;
    logic scl_rise;
    logic scl_fall;
    logic sda_lvl;
    logic sda_rise;
    logic sda_fall;
    logic bus_en;
    logic start_cond;
    logic stop_cond;
    smb_state_e state_ff;
    logic [3:0] bit_cnt_ff;
    logic [7:0] shreg_ff;
    logic [7:0] cmd_ff;
    logic cmd_ok_ff;
    logic rd_mode_ff;
    logic [1:0] byte_idx_ff;
    logic [7:0] low_ff;
    logic [7:0] tx_ff;
    logic [15:0] rd_word_ff;
    logic sda_oe_ff;
    logic wr_stb_ff;
    logic [15:0] wr_data_ff;
    logic [15:0] rd_mux;
    logic cmd_known;
    logic [15:0] option_ff;
    logic [15:0] chg_cur_ff;
    logic [15:0] chg_volt_ff;
    logic [15:0] in_cur_ff;
    logic setting_write;
    logic wdog_en;
    logic [31:0] wdog_limit;
    logic wdog_expired;
    logic suspend_ff;
    logic depl_en;
    logic depl_hit;
    logic learn_on;
    logic learn_done;
    logic deglitch_expired;
    logic [31:0] deglitch_limit;
    logic present_ff;
    logic sw_off_seen_ff;
    logic adapter_sw_ff;
    logic battery_sw_ff;
    logic nxt_adapter_sw;
    logic nxt_battery_sw;
    logic boost_stop_ff;

    line_edge #(.IDLE_LVL(1'b1)) u_scl (
        .mclk(mclk),
        .nrst(nrst),
        .raw(scl_in),
        .level(scl_lvl),
        .rise(scl_rise),
        .fall(scl_fall)
    );

    line_edge #(.IDLE_LVL(1'b1)) u_sda (
        .mclk(mclk),
        .nrst(nrst),
        .raw(sda_in),
        .level(sda_lvl),
        .rise(sda_rise),
        .fall(sda_fall)
    );

    assign bus_en = vcc_above_undervoltage_lockout & detect_above_enable_level;
    assign start_cond = sda_fall & scl_lvl;
    assign stop_cond = sda_rise & scl_lvl;

    // only the six command bytes are acknowledged
    always_comb begin
        case (shreg_ff)
            CMD_OPTION, CMD_CHG_CUR, CMD_CHG_VOLT, CMD_IN_CUR: cmd_known = 1'b1;
            CMD_MAKER_ID, CMD_PART_ID: cmd_known = 1'b1;
            default: cmd_known = 1'b0;
        endcase
    end

    always_comb begin
        case (cmd_ff)
            CMD_OPTION: begin
                rd_mux = option_ff & ~OPTION_RO_MASK;
                rd_mux[OPT_ADAPTER_BIT] = present_ff;
                rd_mux[OPT_BOOST_IND_BIT] = boost_active;
            end
            CMD_CHG_CUR: rd_mux = chg_cur_ff;
            CMD_CHG_VOLT: rd_mux = chg_volt_ff;
            CMD_IN_CUR: rd_mux = in_cur_ff;
            CMD_MAKER_ID: rd_mux = MAKER_ID_VAL;
            CMD_PART_ID: rd_mux = PART_ID_VAL;
            default: rd_mux = 16'h0000;
        endcase
    end

    // serial slave: bytes shift in on scl rise, sda changes on scl fall
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= ST_IDLE;
            bit_cnt_ff <= 4'h0;
            shreg_ff <= 8'h00;
            cmd_ff <= 8'h00;
            cmd_ok_ff <= 1'b0;
            rd_mode_ff <= 1'b0;
            byte_idx_ff <= 2'h0;
            low_ff <= 8'h00;
            tx_ff <= 8'h00;
            rd_word_ff <= 16'h0000;
            sda_oe_ff <= 1'b0;
            wr_stb_ff <= 1'b0;
            wr_data_ff <= 16'h0000;
        end else begin
            wr_stb_ff <= 1'b0;
            if (!bus_en || stop_cond) begin
                state_ff <= ST_IDLE;
                sda_oe_ff <= 1'b0;
                cmd_ok_ff <= 1'b0;
            end else if (start_cond) begin
                state_ff <= ST_ADDR;
                bit_cnt_ff <= 4'h0;
                sda_oe_ff <= 1'b0;
            end else begin
                case (state_ff)
                    ST_ADDR, ST_CMD, ST_WDATA: begin
                        if (scl_rise) begin
                            shreg_ff <= {shreg_ff[6:0], sda_lvl};
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        end else if (scl_fall && bit_cnt_ff == BYTE_BITS) begin
                            bit_cnt_ff <= 4'h0;
                            if (state_ff == ST_ADDR) begin
                                // read only after a command byte was taken
                                if (shreg_ff[7:1] == SLAVE_ADDR7 &&
                                    (!shreg_ff[0] || cmd_ok_ff)) begin
                                    sda_oe_ff <= 1'b1;
                                    state_ff <= ST_ADDR_ACK;
                                    rd_mode_ff <= shreg_ff[0];
                                    rd_word_ff <= rd_mux;
                                end else begin
                                    state_ff <= ST_IDLE;
                                end
                            end else if (state_ff == ST_CMD) begin
                                if (cmd_known) begin
                                    cmd_ff <= shreg_ff;
                                    cmd_ok_ff <= 1'b1;
                                    sda_oe_ff <= 1'b1;
                                    byte_idx_ff <= 2'h0;
                                    state_ff <= ST_CMD_ACK;
                                end else begin
                                    cmd_ok_ff <= 1'b0;
                                    state_ff <= ST_IDLE;
                                end
                            end else if (byte_idx_ff == 2'h0) begin
                                low_ff <= shreg_ff;
                                sda_oe_ff <= 1'b1;
                                state_ff <= ST_WDATA_ACK;
                            end else if (byte_idx_ff == 2'h1) begin
                                // word complete: low byte first, then high
                                wr_stb_ff <= 1'b1;
                                wr_data_ff <= {shreg_ff, low_ff};
                                sda_oe_ff <= 1'b1;
                                state_ff <= ST_WDATA_ACK;
                            end else begin
                                state_ff <= ST_IDLE;
                            end
                        end
                    end
                    ST_ADDR_ACK: begin
                        if (scl_fall) begin
                            bit_cnt_ff <= 4'h0;
                            byte_idx_ff <= 2'h0;
                            if (rd_mode_ff) begin
                                tx_ff <= rd_word_ff[7:0];
                                sda_oe_ff <= ~rd_word_ff[7];
                                state_ff <= ST_RDATA;
                            end else begin
                                sda_oe_ff <= 1'b0;
                                state_ff <= ST_CMD;
                            end
                        end
                    end
                    ST_CMD_ACK, ST_WDATA_ACK: begin
                        if (scl_fall) begin
                            sda_oe_ff <= 1'b0;
                            bit_cnt_ff <= 4'h0;
                            state_ff <= ST_WDATA;
                            if (state_ff == ST_WDATA_ACK) begin
                                byte_idx_ff <= byte_idx_ff + 2'h1;
                            end
                        end
                    end
                    ST_RDATA: begin
                        if (scl_fall) begin
                            if (bit_cnt_ff == LAST_TX_BIT) begin
                                sda_oe_ff <= 1'b0;
                                state_ff <= ST_RDATA_ACK;
                            end else begin
                                tx_ff <= {tx_ff[6:0], 1'b0};
                                sda_oe_ff <= ~tx_ff[6];
                                bit_cnt_ff <= bit_cnt_ff + 4'h1;
                            end
                        end
                    end
                    ST_RDATA_ACK: begin
                        if (scl_rise) begin
                            if (!sda_lvl && byte_idx_ff == 2'h0) begin
                                tx_ff <= rd_word_ff[15:8];
                                byte_idx_ff <= 2'h1;
                            end else begin
                                state_ff <= ST_IDLE;
                            end
                        end else if (scl_fall) begin
                            bit_cnt_ff <= 4'h0;
                            sda_oe_ff <= ~tx_ff[7];
                            state_ff <= ST_RDATA;
                        end
                    end
                    default: begin
                        sda_oe_ff <= 1'b0;
                    end
                endcase
            end
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_ff;

    // option register; a software write wins over the learn auto-clear
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            option_ff <= OPTION_RST;
        end else if (wr_stb_ff && cmd_ff == CMD_OPTION) begin
            option_ff <= wr_data_ff & ~OPTION_RO_MASK;
        end else if (learn_done) begin
            option_ff[OPT_LEARN_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            chg_cur_ff <= CHG_CUR_RST;
        end else if (wr_stb_ff && cmd_ff == CMD_CHG_CUR) begin
            chg_cur_ff <= wr_data_ff & CHG_CUR_MASK;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            chg_volt_ff <= CHG_VOLT_RST;
        end else if (wr_stb_ff && cmd_ff == CMD_CHG_VOLT) begin
            chg_volt_ff <= wr_data_ff & CHG_VOLT_MASK;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            in_cur_ff <= IN_CUR_RST;
        end else if (wr_stb_ff && cmd_ff == CMD_IN_CUR) begin
            in_cur_ff <= wr_data_ff & IN_CUR_MASK;
        end
    end

    // watchdog on setting writes
    assign setting_write = wr_stb_ff && (cmd_ff == CMD_CHG_CUR || cmd_ff == CMD_CHG_VOLT);
    assign wdog_en = option_ff[OPT_WDOG_HI:OPT_WDOG_LO] != WDOG_OFF;
    assign wdog_limit = (boost_active || option_ff[OPT_WDOG_HI:OPT_WDOG_LO] == WDOG_175) ?
        WDOG_LONG_CYC_P : WDOG_SHORT_CYC_P;

    interval_timer #(.W(TMR_W)) u_wdog (
        .mclk(mclk),
        .nrst(nrst),
        .restart(setting_write | ~wdog_en),
        .run(wdog_en),
        .limit(wdog_limit),
        .expired(wdog_expired)
    );

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            suspend_ff <= 1'b0;
        end else if (setting_write || !wdog_en) begin
            suspend_ff <= 1'b0;
        end else if (wdog_expired) begin
            suspend_ff <= 1'b1;
        end
    end

    // battery depletion for learn and boost
    assign depl_en = chg_volt_ff != 16'h0000;
    assign depl_hit = bat_below_depletion & depl_en;
    assign learn_on = option_ff[OPT_LEARN_BIT];
    assign learn_done = learn_on & depl_hit;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            boost_stop_ff <= 1'b0;
        end else begin
            boost_stop_ff <= boost_active & depl_hit;
        end
    end

    // adapter present deglitch; falls at once, rises after the deglitch time
    assign deglitch_limit = (sw_off_seen_ff && option_ff[OPT_DEGLITCH_BIT]) ?
        DEGLITCH_LONG_CYC_P : DEGLITCH_SHORT_CYC_P;

    interval_timer #(.W(TMR_W)) u_deglitch (
        .mclk(mclk),
        .nrst(nrst),
        .restart(~adapter_detect_input),
        .run(adapter_detect_input & ~present_ff),
        .limit(deglitch_limit),
        .expired(deglitch_expired)
    );

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            present_ff <= 1'b0;
        end else if (!adapter_detect_input) begin
            present_ff <= 1'b0;
        end else if (deglitch_expired) begin
            present_ff <= 1'b1;
        end
    end

    // power path switches
    assign nxt_adapter_sw = present_ff & ~(learn_on & ~depl_hit);
    assign nxt_battery_sw = ~present_ff | (learn_on & ~depl_hit) | boost_active;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            adapter_sw_ff <= 1'b0;
            battery_sw_ff <= 1'b0;
        end else begin
            adapter_sw_ff <= nxt_adapter_sw;
            battery_sw_ff <= nxt_battery_sw;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sw_off_seen_ff <= 1'b0;
        end else if (adapter_sw_ff && !nxt_adapter_sw) begin
            sw_off_seen_ff <= 1'b1;
        end
    end

    assign adapter_present_indication = present_ff;
    assign adapter_switch = adapter_sw_ff;
    assign battery_switch = battery_sw_ff;
    assign charge_suspended = suspend_ff;
    assign boost_stop = boost_stop_ff;
    assign depletion_cmp_en = depl_en;
    assign depletion_threshold_sel = option_ff[OPT_DEPL_HI:OPT_DEPL_LO];
    assign freq_adjust_up = option_ff[OPT_FREQ_DIR_BIT];
    assign freq_adjust_en = option_ff[OPT_FREQ_EN_BIT];
    assign high_side_short_threshold = option_ff[OPT_HS_SHORT_BIT];
    assign option_value = option_ff;
    assign charge_current_value = chg_cur_ff;
    assign charge_voltage_value = chg_volt_ff;
    assign input_current_value = in_cur_ff;
endmodule

// ### charger_chk_sva.sv
// port assertions for the charger register bank
`timescale 1ns/1ps
module charger_chk (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic sda_oe,
    input wire logic vcc_above_undervoltage_lockout,
    input wire logic detect_above_enable_level,
    input wire logic bat_below_depletion,
    input wire logic boost_active,
    input wire logic boost_stop,
    input wire logic depletion_cmp_en,
    input wire logic [1:0] depletion_threshold_sel,
    input wire logic freq_adjust_up,
    input wire logic freq_adjust_en,
    input wire logic high_side_short_threshold,
    input wire logic [15:0] option_value,
    input wire logic [15:0] charge_voltage_value
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence bus_off_s;
        !(vcc_above_undervoltage_lockout && detect_above_enable_level) [*3];
    endsequence
    sequence depleted_s;
        boost_active && bat_below_depletion && depletion_cmp_en;
    endsequence
    freq_dir_a: assert property (freq_adjust_up == option_value[10])
        else $error("freq dir");
    freq_en_a: assert property (freq_adjust_en == option_value[9])
        else $error("freq enable");
    hs_short_a: assert property (high_side_short_threshold == option_value[8])
        else $error("short cmp");
    depl_sel_a: assert property (depletion_threshold_sel == option_value[12:11])
        else $error("depl sel");
    depl_en_a: assert property (depletion_cmp_en == (charge_voltage_value != 16'h0000))
        else $error("depl enable");
    boost_stop_a: assert property (depleted_s |=> boost_stop) else $error("boost");
    bus_quiet_a: assert property (bus_off_s |-> !sda_oe) else $error("ack off");
    bus_hold_a: assert property (bus_off_s |-> $stable(charge_voltage_value))
        else $error("write off");
endmodule
bind charger_command_register_bank charger_chk chk (.mclk, .nrst, .sda_oe,
    .vcc_above_undervoltage_lockout, .detect_above_enable_level, .bat_below_depletion,
    .boost_active, .boost_stop, .depletion_cmp_en, .depletion_threshold_sel, .freq_adjust_up,
    .freq_adjust_en, .high_side_short_threshold, .option_value, .charge_voltage_value);

// ### smb_host.sv
// serial bus host model issuing word transfers
`timescale 1ns/1ps
module smb_host (
    input wire logic mclk,
    input wire logic sda,
    output logic scl = 1'b1,
    output logic pull_low = 1'b0,
    output logic rd_valid = 1'b0,
    output logic [15:0] rd_data = 16'h0000,
    output logic acked = 1'b0
);
    task automatic t(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // a=0 start or repeated start, a=1 stop
    task automatic cond(input logic a);
        t(1);
        pull_low = a;
        t(4);
        scl = 1'b1;
        t(4);
        pull_low = ~a;
        t(4);
        scl = a;
    endtask
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            t(1);
            pull_low = ~d[i];
            t(3);
            scl = 1'b1;
            t(2);
            q[i] = sda;
            t(2);
            scl = 1'b0;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] c, input logic [15:0] d);
        logic [8:0] q0, q1, q2, q3;
        cond(1'b0);
        xfer({a, 1'b1}, q0);
        xfer({c, 1'b1}, q1);
        xfer({d[7:0], 1'b1}, q2);
        xfer({d[15:8], 1'b1}, q3);
        cond(1'b1);
        acked = ~(q0[0] | q1[0] | q2[0] | q3[0]);
    endtask
    task automatic rd(input logic [7:0] c);
        logic [8:0] q0, q1, q2, q3, q4;
        cond(1'b0);
        xfer(9'h025, q0);
        xfer({c, 1'b1}, q1);
        cond(1'b0);
        xfer(9'h027, q2);
        xfer(9'h1FE, q3);
        xfer(9'h1FF, q4);
        cond(1'b1);
        rd_data = {q4[8:1], q3[8:1]};
        rd_valid = 1'b1;
        t(1);
        rd_valid = 1'b0;
    endtask
endmodule

// ### charger_command_register_bank_tb.sv
// self-checking bench for the charger register bank
`timescale 1ns/1ps
module charger_command_register_bank_tb import charger_pkg::*;;
    logic mclk = 1'b0, nrst = 1'b0, det = 1'b1, lo = 1'b0, bst = 1'b0, vcc = 1'b1, adi = 1'b0;
    logic scl, pl, sda_oe, rv, ack, susp, stp, api;
    logic [15:0] rdd, vlt, d, m, exp_q[$];
    logic [31:0] seed = 32'h9439EF73;
    int error_cnt = 0, checks_done = 0, n, k;
    wire logic sda = ~pl & ~sda_oe;
    logic [7:0] cmd[6] = '{CMD_OPTION, CMD_CHG_CUR, CMD_CHG_VOLT, CMD_IN_CUR, 8'hFE, 8'hFF};
    logic [15:0] rst[6] = '{OPTION_RST, 16'h0000, 16'h0000, IN_CUR_RST, MAKER_ID_VAL, PART_ID_VAL};
    logic [15:0] msk[6] = '{16'hFFEB, CHG_CUR_MASK, CHG_VOLT_MASK, IN_CUR_MASK, 16'h0000, 16'h0000};
    charger_command_register_bank #(.WDOG_SHORT_CYC_P(32'h000001F4),
        .WDOG_LONG_CYC_P(32'h000003E8), .DEGLITCH_SHORT_CYC_P(32'h00000014),
        .DEGLITCH_LONG_CYC_P(32'h00000028)) DUT (.mclk, .nrst, .scl_in(scl), .sda_in(sda),
        .sda_out(), .sda_oe, .vcc_above_undervoltage_lockout(vcc),
        .detect_above_enable_level(det), .adapter_detect_input(adi), .bat_below_depletion(lo),
        .boost_active(bst), .adapter_present_indication(api), .adapter_switch(), .battery_switch(),
        .charge_suspended(susp), .boost_stop(stp), .depletion_cmp_en(),
        .depletion_threshold_sel(), .freq_adjust_up(), .freq_adjust_en(),
        .high_side_short_threshold(), .option_value(), .charge_current_value(),
        .charge_voltage_value(vlt), .input_current_value());
    smb_host host (.mclk, .sda, .scl, .pull_low(pl), .rd_valid(rv), .rd_data(rdd), .acked(ack));
    initial begin
        forever #50 mclk = ~mclk;
    end
    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checks_done++;
        if (seen !== want) begin
            error_cnt++;
            $display("CHECK FAILED at %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge rv) begin
        check(rdd, exp_q.pop_front());
    end
    initial begin
        host.t(2);
        nrst = 1'b1;
        host.t(2);
        // first pass reads reset values, second writes random data then reads back
        for (int i = 0; i < 12; i++) begin
            k = i % 6;
            d = rnd();
            m = i < 6 ? 16'h0000 : msk[k];
            if (i > 5) host.wr(8'h12, cmd[k], d);
            exp_q.push_back((d & m) | (rst[k] & ~m));
            host.rd(cmd[k]);
        end
        $display("register test done");
        host.wr(8'h14, CMD_CHG_CUR, 16'h0040);
        check(16'(ack), 16'h0000);
        host.wr(8'h12, 8'h20, 16'h0040);
        check(16'(ack), 16'h0000);
        host.wr(8'h12, CMD_CHG_VOLT, 16'h1230);
        {vcc, det} = seed[0] ? 2'b10 : 2'b01;
        host.wr(8'h12, CMD_CHG_VOLT, 16'h0FF0);
        check(16'(ack), 16'h0000);
        check(vlt, 16'h1230);
        {vcc, det} = 2'b11;
        $display("refusal test done");
        host.wr(8'h12, CMD_OPTION, 16'hB902);
        host.wr(8'h12, CMD_CHG_CUR, 16'h0FC0);
        check(16'(susp), 16'h0000);
        n = 0;
        while (susp !== 1'b1 && n < 700) begin
            host.t(1);
            n++;
        end
        check(16'(susp), 16'h0001);
        check(16'(n > 400), 16'h0001);
        if (n == 700) test_done();
        host.wr(8'h12, CMD_CHG_VOLT, 16'h1230);
        check(16'(susp), 16'h0000);
        $display("watchdog test done");
        bst = 1'b1;
        lo = 1'b1;
        adi = 1'b1;
        host.t(30);
        check(16'(stp), 16'h0001);
        check(16'(api), 16'h0001);
        $display("boost test done");
        test_done();
    end
endmodule
